// *** rtl/blmlc_top.sv ***
`timescale 1ns/1ps
`include "blmlc_regs.svh"

module blmlc_top (
   // clock and reset
   input  wire logic MCLK,
   input  wire logic NRST,
   // stored state, offered once after reset
   input  wire logic NV_LOAD,
   input  wire blmlc_pkg::blmlc_flag_t NV_FLASH_BOOT,
   input  wire logic NV_LOCKED,
   input  wire logic NV_NORMAL,
   // write-back to storage
   output logic      NV_WR,
   output logic      NV_WR_FLASH_BOOT,
   output logic      NV_WR_LOCKED,
   output logic      NV_WR_NORMAL,
   // life-cycle requests, one-cycle pulses
   input  wire logic SEL_FLASH_REQ,
   input  wire logic SEL_ROM_REQ,
   input  wire logic LOCK_REQ,
   input  wire logic NORMAL_REQ,
   // test protocol
   input  wire logic TEST_AUTH_OK,
   input  wire logic TEST_CMD_VALID,
   output logic      TEST_CMD_ACCEPT,
   output logic      TEST_CMD_REJECT,
   // bootloader command packets
   input  wire logic BL_CMD_VALID,
   input  wire logic BL_CMD_FLASH,
   output logic      BL_CMD_ACCEPT,
   output logic      BL_CMD_REJECT,
   // status
   output logic      ROM_BOOT,
   output logic      FLASH_BOOT,
   output logic      BOOT_LOCKED,
   output logic      NORMAL_MODE,
   output logic      TEST_MODE,
   output logic      BL_ENABLE
);
   import blmlc_pkg::*;

   blmlc_lc_e   lc_q;        // load sequencer
   blmlc_boot_e boot_q;      // current boot domain
   blmlc_boot_e boot_d;
   logic        locked_q;    // boot lock, one-way
   logic        normal_q;    // normal mode, one-way
   logic        test_q;      // test session authenticated
   logic        run;         // stored state is in
   logic        load;        // restore strobe
   logic        lock_set;    // accepted lock request
   logic        normal_set;  // accepted normal request
   logic        chg;         // persistent state changes this cycle

   assign run  = (lc_q == BLMLC_LC_RUN);
   assign load = (lc_q == BLMLC_LC_WAIT) && NV_LOAD;

   // sequencer: requests before the stored copy arrives would act on
   // reset values, so they are all ignored until then
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         lc_q <= BLMLC_LC_WAIT;
      end else begin
         case (lc_q)
            BLMLC_LC_WAIT: begin
               if (NV_LOAD) begin
                  lc_q <= BLMLC_LC_RUN;
               end
            end
            BLMLC_LC_RUN: begin
               lc_q <= BLMLC_LC_RUN;
            end
            default: begin
               lc_q <= BLMLC_LC_WAIT;   // illegal code: restart safely
            end
         endcase
      end
   end

   // next boot domain; only one code is ever formed
   always_comb begin
      boot_d = boot_q;
      if (load) begin
         boot_d = NV_FLASH_BOOT ? BLMLC_BOOT_FLASH
                                : BLMLC_BOOT_ROM;
      end else if (run && !locked_q) begin
         if (SEL_FLASH_REQ) begin
            boot_d = BLMLC_BOOT_FLASH;
         end else if (SEL_ROM_REQ) begin
            boot_d = BLMLC_BOOT_ROM;
         end
      end
   end

   // boot domain register, one-hot enum keeps domains exclusive
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         boot_q <= BLMLC_BOOT_ROM;
      end else begin
         boot_q <= boot_d;
      end
   end

   // lock only from flash boot and not in the same cycle as a move
   // back to ROM, so a locked device is always in flash boot
   assign lock_set = run && LOCK_REQ && !SEL_ROM_REQ &&
                     (boot_q == BLMLC_BOOT_FLASH);
   assign normal_set = run && NORMAL_REQ;

   // one-way lock flag
   blmlc_oneway #(
      .RST_VAL (`BLMLC_RST_LOCKED)
   ) u_lock (
      .clk      (MCLK),
      .rst_n    (NRST),
      .load     (load),
      .load_val (NV_LOCKED && NV_FLASH_BOOT),
      .set      (lock_set),
      .q        (locked_q)
   );

   // one-way normal-mode flag
   blmlc_oneway #(
      .RST_VAL (`BLMLC_RST_NORMAL)
   ) u_normal (
      .clk      (MCLK),
      .rst_n    (NRST),
      .load     (load),
      .load_val (NV_NORMAL),
      .set      (normal_set),
      .q        (normal_q)
   );

   // test session: opened by a valid password, closed for good by
   // normal mode; never survives reset, so each session re-authenticates
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         test_q <= `BLMLC_RST_TEST;
      end else if (normal_q || normal_set) begin
         test_q <= 1'b0;
      end else if (run && TEST_AUTH_OK) begin
         test_q <= 1'b1;
      end
   end

   // test command answer, registered one cycle after the request
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         TEST_CMD_ACCEPT <= 1'b0;
         TEST_CMD_REJECT <= 1'b0;
      end else begin
         TEST_CMD_ACCEPT <= TEST_CMD_VALID && test_q && !normal_q;
         TEST_CMD_REJECT <= TEST_CMD_VALID &&
                            !(test_q && !normal_q);
      end
   end

   // bootloader answer: only ROM boot serves packets; flash boot (and
   // above all locked flash boot) refuses flash access and all else
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         BL_CMD_ACCEPT <= 1'b0;
         BL_CMD_REJECT <= 1'b0;
      end else begin
         BL_CMD_ACCEPT <= BL_CMD_VALID && run &&
                          (boot_q == BLMLC_BOOT_ROM);
         BL_CMD_REJECT <= BL_CMD_VALID &&
                          !(run && boot_q == BLMLC_BOOT_ROM);
      end
   end

   // write-back: every change of persistent state is pushed out with
   // the full new image, so storage never holds a half update
   assign chg = run && ((boot_d != boot_q) ||
                        (lock_set && !locked_q) ||
                        (normal_set && !normal_q));
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         NV_WR            <= 1'b0;
         NV_WR_FLASH_BOOT <= 1'b0;
         NV_WR_LOCKED     <= 1'b0;
         NV_WR_NORMAL     <= 1'b0;
      end else begin
         NV_WR <= chg;
         if (chg) begin
            NV_WR_FLASH_BOOT <= (boot_d == BLMLC_BOOT_FLASH);
            NV_WR_LOCKED     <= locked_q || lock_set;
            NV_WR_NORMAL     <= normal_q || normal_set;
         end
      end
   end

   // status, straight from flops
   assign ROM_BOOT    = boot_q[`BLMLC_BOOT_ROM_BIT];
   assign FLASH_BOOT  = boot_q[`BLMLC_BOOT_FLASH_BIT];
   assign BOOT_LOCKED = locked_q;
   assign NORMAL_MODE = normal_q;
   assign TEST_MODE   = test_q && !normal_q;
   // bootloader may start only in ROM boot once state is known
   assign BL_ENABLE   = run && (boot_q == BLMLC_BOOT_ROM);

   boot_onehot_a: assert property (
      @(posedge MCLK) disable iff (!NRST) $onehot(boot_q))
      else $error("boot domain not one-hot");

   lock_flash_a: assert property (
      @(posedge MCLK) disable iff (!NRST)
      locked_q |-> (FLASH_BOOT && !BL_ENABLE))
      else $error("locked device not in flash boot");

   lock_sticky_a: assert property (
      @(posedge MCLK) disable iff (!NRST)
      (run && locked_q) |=> (locked_q && $stable(boot_q)))
      else $error("locked selection changed");

   lock_entry_a: assert property (
      @(posedge MCLK) disable iff (!NRST)
      (run && LOCK_REQ && !locked_q && FLASH_BOOT && !SEL_ROM_REQ)
      |=> (locked_q && FLASH_BOOT))
      else $error("lock request from flash boot not honoured");

   bl_flash_rej_a: assert property (
      @(posedge MCLK) disable iff (!NRST)
      (BL_CMD_VALID && BL_CMD_FLASH && locked_q)
      |=> (BL_CMD_REJECT && !BL_CMD_ACCEPT))
      else $error("flash command served while locked");

   bl_domain_a: assert property (
      @(posedge MCLK) disable iff (!NRST)
      (BL_CMD_VALID && run) |=> (BL_CMD_ACCEPT == $past(ROM_BOOT)))
      else $error("bootloader answer disagrees with domain");

   normal_oneway_a: assert property (
      @(posedge MCLK) disable iff (!NRST)
      (run && normal_q) |=> (normal_q [*3]))
      else $error("normal mode reverted");

   test_entry_a: assert property (
      @(posedge MCLK) disable iff (!NRST)
      $rose(test_q) |-> ($past(TEST_AUTH_OK) && !normal_q))
      else $error("test mode without password");

   test_cmd_a: assert property (
      @(posedge MCLK) disable iff (!NRST)
      (TEST_CMD_VALID && normal_q) |=> TEST_CMD_REJECT)
      else $error("test command served in normal mode");

   nv_store_a: assert property (
      @(posedge MCLK) disable iff (!NRST)
      (run && $past(run) && $rose(locked_q)) |-> (NV_WR && NV_WR_LOCKED))
      else $error("lock not written to storage");

endmodule

// *** rtl/blmlc_regs.svh ***
// Operation
// - ROM-to-flash boot selection, then lockable
// - locked flash boot never starts bootloader
// - locked: reject flash read/download/modify commands
// - after lock, selection changes are ignored
// - exactly one boot domain at all times
// - bootloader commands accepted only in ROM boot
// - one-time TEST to NORMAL, no return
// - TEST needs password; NORMAL refuses test commands
`ifndef BLMLC_REGS_SVH
`define BLMLC_REGS_SVH

// one-hot codes of the two boot domains
`define BLMLC_BOOT_ROM_CODE   2'h1
`define BLMLC_BOOT_FLASH_CODE 2'h2
// bit positions inside the boot selection code
`define BLMLC_BOOT_ROM_BIT    0
`define BLMLC_BOOT_FLASH_BIT  1
// one-hot codes of the load sequencer
`define BLMLC_LC_WAIT_CODE    2'h1
`define BLMLC_LC_RUN_CODE     2'h2
// reset values held until the stored copy arrives
`define BLMLC_RST_LOCKED      1'h0
`define BLMLC_RST_NORMAL      1'h0
`define BLMLC_RST_TEST        1'h0

`endif

// *** rtl/blmlc_pkg.sv ***
`include "blmlc_regs.svh"

package blmlc_pkg;

   // boot domain, one-hot so both-at-once is a visible illegal code
   typedef enum logic [1:0] {
      BLMLC_BOOT_ROM   = `BLMLC_BOOT_ROM_CODE,
      BLMLC_BOOT_FLASH = `BLMLC_BOOT_FLASH_CODE
   } blmlc_boot_e;

   // load sequencer: nothing is honoured until the stored state is in
   typedef enum logic [1:0] {
      BLMLC_LC_WAIT = `BLMLC_LC_WAIT_CODE,
      BLMLC_LC_RUN  = `BLMLC_LC_RUN_CODE
   } blmlc_lc_e;

   // single status flag
   typedef logic blmlc_flag_t;

endpackage

// *** rtl/blmlc_oneway.sv ***
`timescale 1ns/1ps

// one-way flag: restored once from storage, afterwards it can only be set
module blmlc_oneway #(
   parameter logic RST_VAL = 1'b0
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // restore from storage
   input  wire logic load,
   input  wire logic load_val,
   // one-way set request
   input  wire logic set,
   // flag
   output logic      q
);

   // apart from reset and the restore, no clear path exists, so a glitch on a set request can only
   // move the flag toward the safe side
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RST_VAL;
      end else if (load) begin
         q <= load_val;       // stored copy wins at start-up
      end else if (set) begin
         q <= 1'b1;
      end
   end

endmodule

// *** verif/blmlc_store.sv ***
`timescale 1ns/1ps

// storage model: keeps the image across resets, offers it once after each
module blmlc_store #(
   parameter int LOAD_DLY = 4
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // write-back from the block
   input  wire logic nv_wr,
   input  wire logic wr_flash,
   input  wire logic wr_locked,
   input  wire logic wr_normal,
   // restore towards the block
   output logic      nv_load,
   output logic      nv_flash,
   output logic      nv_locked,
   output logic      nv_normal
);
   logic [2:0] img_q = 3'h0; // image, untouched by reset
   int         cnt_q;        // cycles since reset release

   // capture every written image, so it outlives the next reset
   always @(posedge clk) begin
      if (nv_wr) begin
         img_q <= {wr_flash, wr_locked, wr_normal};
      end
   end

   // the restore strobe comes late, to exercise the waiting state
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 0;
      end else if (cnt_q <= LOAD_DLY) begin
         cnt_q <= cnt_q + 1;
      end
   end
   assign nv_load = (cnt_q == LOAD_DLY);
   // data is only good with the strobe; otherwise show the inverse
   assign {nv_flash, nv_locked, nv_normal} = nv_load ? img_q : ~img_q;
endmodule

// *** verif/tb_boot_mode_lock_control.sv ***
`timescale 1ns/1ps

module tb_boot_mode_lock_control;
   logic       mclk = 1'b0;  // 100 MHz clock
   logic       nrst = 1'b0;  // reset, active low
   logic [7:0] req  = 8'h00; // bl_fl, bl, tcmd, auth, nrm, lock, rom, fl
   logic nv_load, nv_fb, nv_lk, nv_nm, nv_wr, wr_fb, wr_lk, wr_nm;
   logic t_acc, t_rej, b_acc, b_rej, rom, fl, lkd, nrm, tst, ble;
   int   err_count = 0;   // mismatches
   int   checks_done = 0; // comparisons
   int   cyc = 0;         // cycle count for the hang guard

   always #5 mclk = ~mclk;

   blmlc_top blmlc_top_inst (
      .MCLK(mclk), .NRST(nrst), .NV_LOAD(nv_load),
      .NV_FLASH_BOOT(nv_fb), .NV_LOCKED(nv_lk), .NV_NORMAL(nv_nm),
      .NV_WR(nv_wr), .NV_WR_FLASH_BOOT(wr_fb), .NV_WR_LOCKED(wr_lk),
      .NV_WR_NORMAL(wr_nm), .SEL_FLASH_REQ(req[0]), .SEL_ROM_REQ(req[1]),
      .LOCK_REQ(req[2]), .NORMAL_REQ(req[3]), .TEST_AUTH_OK(req[4]),
      .TEST_CMD_VALID(req[5]), .TEST_CMD_ACCEPT(t_acc),
      .TEST_CMD_REJECT(t_rej), .BL_CMD_VALID(req[6]),
      .BL_CMD_FLASH(req[7]), .BL_CMD_ACCEPT(b_acc), .BL_CMD_REJECT(b_rej),
      .ROM_BOOT(rom), .FLASH_BOOT(fl), .BOOT_LOCKED(lkd),
      .NORMAL_MODE(nrm), .TEST_MODE(tst), .BL_ENABLE(ble));

   blmlc_store blmlc_store_inst (
      .clk(mclk), .rst_n(nrst), .nv_wr(nv_wr), .wr_flash(wr_fb),
      .wr_locked(wr_lk), .wr_normal(wr_nm), .nv_load(nv_load),
      .nv_flash(nv_fb), .nv_locked(nv_lk), .nv_normal(nv_nm));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // a hung wait must not stall the run forever
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 500) begin
         err_count++;
         stop_test();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one request pulse, then status {rom,fl,lkd,nrm,tst,ble} and
   // pulses {nv_wr,b_acc,b_rej,t_acc,t_rej} 1 ns after the edge that takes the request
   task automatic step(input logic [7:0] v, input logic [5:0] st,
                       input logic [4:0] pl);
      @(posedge mclk) req <= v;
      @(posedge mclk) req <= 8'h00;
      #1;
      chk({2'h0, rom, fl, lkd, nrm, tst, ble}, {2'h0, st});
      chk({3'h0, nv_wr, b_acc, b_rej, t_acc, t_rej}, {3'h0, pl});
   endtask

   // reset, one refused command before restore, then wait for restore
   task automatic do_reset();
      @(posedge mclk) nrst <= 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      step(8'h40, 6'h20, 5'h04);
      while (nv_load !== 1'b1) @(posedge mclk);
      @(posedge mclk);
      #1;
   endtask

   task automatic t_fresh();
      do_reset();
      chk({2'h0, rom, fl, lkd, nrm, tst, ble}, 8'h21);
      step(8'h40, 6'h21, 5'h08);
      step(8'hC0, 6'h21, 5'h08);
      step(8'h20, 6'h21, 5'h01);
      step(8'h04, 6'h21, 5'h00);
      $display("test fresh done");
   endtask

   // move back to ROM with a lock in the same cycle: ROM wins, no lock;
   // both selections at once: flash wins
   task automatic t_lock();
      step(8'h01, 6'h10, 5'h10);
      chk({5'h0, wr_fb, wr_lk, wr_nm}, 8'h04);
      step(8'h06, 6'h21, 5'h10);
      chk({5'h0, wr_fb, wr_lk, wr_nm}, 8'h00);
      step(8'h03, 6'h10, 5'h10);
      step(8'h40, 6'h10, 5'h04);
      step(8'h04, 6'h18, 5'h10);
      chk({5'h0, wr_fb, wr_lk, wr_nm}, 8'h06);
      step(8'h02, 6'h18, 5'h00);
      step(8'h03, 6'h18, 5'h00);
      step(8'hC0, 6'h18, 5'h04);
      $display("test lock done");
   endtask

   task automatic t_mode();
      do_reset();
      chk({2'h0, rom, fl, lkd, nrm, tst, ble}, 8'h18);
      step(8'h10, 6'h1A, 5'h00);
      step(8'h20, 6'h1A, 5'h02);
      step(8'h08, 6'h1C, 5'h10);
      chk({5'h0, wr_fb, wr_lk, wr_nm}, 8'h07);
      step(8'h20, 6'h1C, 5'h01);
      step(8'h10, 6'h1C, 5'h00);
      do_reset();
      chk({2'h0, rom, fl, lkd, nrm, tst, ble}, 8'h1C);
      $display("test mode done");
   endtask

   initial begin
      t_fresh();
      t_lock();
      t_mode();
      stop_test();
   end
endmodule
